//--- lbpt_pkg.sv
package lbpt_pkg;

	// Register offsets
	localparam logic [11:0] OFS_PAT0 = 12'h210;
	localparam logic [11:0] OFS_PAT1 = 12'h214;
	localparam logic [11:0] OFS_PAT2 = 12'h218;
	localparam logic [11:0] OFS_PAT3 = 12'h21C;
	localparam logic [11:0] OFS_CMD_STAT = 12'h220;
	localparam logic [11:0] OFS_TEST_CTL = 12'h228;
	localparam logic [11:0] OFS_SKIP_CTL = 12'h234;
	localparam logic [11:0] OFS_DIAG = 12'h238;
	localparam logic [11:0] OFS_SERIALIZER_TEST_CONTROL = 12'hB88;

	// Lane slots: 0 = lane 0, 1 = lane 2, 2 = serial PHY lane
	localparam int NUM_LANES = 3;
	// User pattern enable bit per slot in the test control register
	localparam int UP_EN_BIT0 = 28;
	localparam int UP_EN_BIT1 = 30;
	localparam int UP_EN_BIT2 = 31;
	// PRBS enable bit per slot in the serializer test register
	localparam int PRBS_EN_BIT0 = 16;
	localparam int PRBS_EN_BIT1 = 18;
	localparam int PRBS_EN_BIT2 = 19;

	// Field positions
	localparam int KFLAG_LSB = 16;
	localparam int DIAG_EXP_LSB = 0;
	localparam int DIAG_ACT_LSB = 8;
	localparam int DIAG_CNT_LSB = 16;
	localparam int DIAG_SEL_LSB = 24;
	localparam int DIAG_TYPE_BIT = 30;

	// Select codes
	localparam logic [1:0] SEL_LANE0 = 2'h0;
	localparam logic [1:0] SEL_RSVD = 2'h1;
	localparam logic [1:0] SEL_LANE2 = 2'h2;
	localparam logic [1:0] SEL_PHY = 2'h3;

	// Reset values and fixed symbols
	localparam logic [11:0] SKIP_INTERVAL_RST = 12'd1180;
	localparam logic [31:0] SYNC_WORD = 32'h314D_5243;
	localparam logic [7:0] SYM_COM = 8'hBC;
	localparam logic [7:0] SYM_SKP = 8'h1C;
	localparam logic [7:0] CNT_SAT = 8'hFF;
	localparam logic [1:0] COM_LOCK_COUNT = 2'd3;
	localparam logic [3:0] SKIP_SET_LEN = 4'd4;

endpackage : lbpt_pkg

//--- lbpt_tester.sv
// How it works
// - Per-lane enable bit starts user pattern
// - SKIP sets at pattern boundary after interval
// - Checker drops SKIP sets, compares rest
// - One shared 16-byte pattern, byte 0 first
// - Flag bit makes byte a control symbol
// - Sync word sent before pattern bytes
// - Checker compares only after sync word found
// - No sync word drives count to 255
// - Count in 23:16, bit 30 pattern type
// - First failing expected and actual byte captured
// - Select field picks reported lane
// - Saturating count, cleared by zero write/re-enable
// - Symbol lock after three aligned COMs
// - Enable switches transmit path unconditionally
// - No SKIP in PRBS; returned SKIP errors
// - PRBS raw symbol every clock, no coding
// - PRBS checker locks reference, then compares
// - One count per mismatched symbol
// - Select 00 lane0, 10 lane2, 11 PHY

module lbpt_lane #(
	parameter int SYM_W = 10,
	parameter int SYNC_WAIT = 1024,
	parameter int PRBS_LOCK_N = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic up_en,
	input wire logic prbs_en,
	input wire logic [127:0] pattern,
	input wire logic [15:0] kflags,
	input wire logic [11:0] skip_interval,
	input wire logic cnt_clr,
	// Receive side
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_k,
	input wire logic rx_com_hit,
	input wire logic rx_com_slip,
	input wire logic [SYM_W-1:0] rx_raw,
	// Transmit side
	output logic [7:0] tx_byte,
	output logic tx_k,
	output logic [SYM_W-1:0] tx_raw,
	output logic tx_raw_sel,
	// Results
	output logic [7:0] err_cnt,
	output logic [7:0] exp_byte,
	output logic [7:0] act_byte
);
	typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_PAT, TX_SKIP} lbpt_tx_t;
	typedef enum logic {RX_HUNT, RX_CHECK} lbpt_rx_t;

	// Advance a 7-bit PRBS state over one symbol, bit 0 first
	function automatic logic [SYM_W+6:0] prbs_run(input logic [6:0] s);
		logic [6:0] st;
		logic [SYM_W-1:0] sym;
		st = s;
		sym = '0;
		for (int i = 0; i < SYM_W; i++)
		begin
			sym[i] = st[6] ^ st[5];
			st = {st[5:0], sym[i]};
		end
		return {sym, st};
	endfunction : prbs_run

	// Shift a received symbol into a history state
	function automatic logic [6:0] hist_run(input logic [6:0] s,
			input logic [SYM_W-1:0] sym);
		logic [6:0] st;
		st = s;
		for (int i = 0; i < SYM_W; i++)
			st = {st[5:0], sym[i]};
		return st;
	endfunction : hist_run

	lbpt_tx_t tx_st_q, tx_st_d;
	logic [3:0] tx_idx_q, tx_idx_d;
	logic [11:0] skip_cnt_q, skip_cnt_d; // Symbol times since a SKIP last fell due
	logic skip_due_q, skip_due_d;
	logic up_en_q; // For rising-edge detection
	logic [7:0] tx_byte_d;
	logic tx_k_d;
	logic [SYM_W-1:0] tx_raw_d;
	logic [6:0] gen_q, gen_d; // PRBS generator state
	lbpt_rx_t rx_st_q, rx_st_d;
	logic [3:0] rx_idx_q, rx_idx_d;
	logic [1:0] lock_q, lock_d; // Consecutive aligned COM count
	logic [$clog2(SYNC_WAIT+1)-1:0] hunt_q, hunt_d;
	logic [7:0] cnt_d, exp_d, act_d;
	logic fail_seen_q, fail_seen_d;
	logic [6:0] hist_q, hist_d, ref_q, ref_d;
	logic [$clog2(PRBS_LOCK_N+1)-1:0] plock_q, plock_d;
	logic plocked_q, plocked_d;
	logic up_rise, rx_skip, miss, bump;
	logic [7:0] sync_b, exp_b;
	logic [7:0] sync_r; // Expected sync byte on receive, own driver
	logic [SYM_W+6:0] gen_nx, chk_nx;

	assign up_rise = up_en && !up_en_q;
	// Ordered-set symbols that the far end may add or drop
	assign rx_skip = rx_k && (rx_byte == lbpt_pkg::SYM_COM ||
		rx_byte == lbpt_pkg::SYM_SKP);
	assign gen_nx = prbs_run(gen_q);
	assign chk_nx = prbs_run(plocked_q ? ref_q : hist_q);

	// Transmit sequencer
	always_comb
	begin
		tx_st_d = tx_st_q;
		tx_idx_d = tx_idx_q;
		skip_due_d = skip_due_q;
		skip_cnt_d = skip_cnt_q;
		tx_byte_d = 8'h00;
		tx_k_d = 1'b0;
		sync_b = lbpt_pkg::SYNC_WORD[8'(31 - 8 * tx_idx_q[1:0]) -: 8];
		if (tx_st_q != TX_IDLE && skip_cnt_q >= skip_interval)
		begin
			skip_due_d = 1'b1;
			skip_cnt_d = 12'h000;
		end
		else if (tx_st_q != TX_IDLE)
			skip_cnt_d = skip_cnt_q + 12'h001;
		unique case (tx_st_q)
			TX_IDLE:
				tx_idx_d = 4'h0;
			TX_SYNC:
			begin
				tx_byte_d = sync_b;
				tx_idx_d = tx_idx_q + 4'h1;
				if (tx_idx_q == 4'h3)
				begin
					tx_st_d = TX_PAT;
					tx_idx_d = 4'h0;
				end
			end
			TX_PAT:
			begin
				tx_byte_d = pattern[8 * tx_idx_q +: 8];
				tx_k_d = kflags[tx_idx_q];
				tx_idx_d = tx_idx_q + 4'h1;
				if (tx_idx_q == 4'hF && skip_due_q)
					tx_st_d = TX_SKIP;
			end
			TX_SKIP:
			begin
				tx_k_d = 1'b1;
				tx_byte_d = (tx_idx_q == 4'h0) ? lbpt_pkg::SYM_COM :
					lbpt_pkg::SYM_SKP;
				skip_due_d = 1'b0;
				tx_idx_d = tx_idx_q + 4'h1;
				if (tx_idx_q == lbpt_pkg::SKIP_SET_LEN - 4'h1)
				begin
					tx_st_d = TX_PAT;
					tx_idx_d = 4'h0;
				end
			end
		endcase
		// Enable wins at once, whatever the link is doing
		if (up_rise)
		begin
			tx_st_d = TX_SYNC;
			tx_idx_d = 4'h0;
			skip_cnt_d = 12'h000;
			skip_due_d = 1'b0;
		end
		else if (!up_en)
			tx_st_d = TX_IDLE;
		// Raw PRBS bypass, never with SKIP sets
		gen_d = prbs_en ? gen_nx[6:0] : gen_q;
		tx_raw_d = prbs_en ? gen_nx[SYM_W+6:7] : '0;
	end

	// Receive checkers and result capture
	always_comb
	begin
		rx_st_d = rx_st_q;
		rx_idx_d = rx_idx_q;
		hunt_d = hunt_q;
		cnt_d = err_cnt;
		exp_d = exp_byte;
		act_d = act_byte;
		fail_seen_d = fail_seen_q;
		hist_d = hist_q;
		ref_d = ref_q;
		plock_d = plock_q;
		plocked_d = plocked_q;
		miss = 1'b0;
		bump = 1'b0;
		sync_r = 8'h00;
		exp_b = pattern[8 * rx_idx_q +: 8];
		// Framer lock from aligned COMs
		lock_d = lock_q;
		if (rx_com_slip)
			lock_d = 2'd0;
		else if (rx_com_hit && lock_q != lbpt_pkg::COM_LOCK_COUNT)
			lock_d = lock_q + 2'd1;
		if (up_en && rx_valid && !rx_skip)
		begin
			unique case (rx_st_q)
				RX_HUNT:
				begin
					sync_r = lbpt_pkg::SYNC_WORD[8'(31 - 8 * rx_idx_q[1:0]) -: 8];
					if (lock_q != lbpt_pkg::COM_LOCK_COUNT)
						rx_idx_d = 4'h0;
					else if (!rx_k && rx_byte == sync_r)
					begin
						rx_idx_d = rx_idx_q + 4'h1;
						if (rx_idx_q == 4'h3)
						begin
							rx_st_d = RX_CHECK;
							rx_idx_d = 4'h0;
						end
					end
					else
						rx_idx_d = (!rx_k && rx_byte == lbpt_pkg::SYNC_WORD[31:24])
							? 4'h1 : 4'h0;
				end
				RX_CHECK:
				begin
					rx_idx_d = rx_idx_q + 4'h1;
					miss = rx_byte != exp_b || rx_k != kflags[rx_idx_q];
				end
			endcase
		end
		// Sync never arrives: counter pinned at saturation
		if (up_en && rx_st_q == RX_HUNT)
		begin
			if (hunt_q == SYNC_WAIT[$bits(hunt_q)-1:0])
				cnt_d = lbpt_pkg::CNT_SAT;
			else
				hunt_d = hunt_q + 1'b1;
		end
		// PRBS: lock reference on received data, then compare
		if (prbs_en && rx_valid)
		begin
			hist_d = hist_run(hist_q, rx_raw);
			if (!plocked_q)
			begin
				if (chk_nx[SYM_W+6:7] != rx_raw)
					plock_d = '0;
				else if (plock_q == PRBS_LOCK_N[$bits(plock_q)-1:0])
				begin
					plocked_d = 1'b1;
					ref_d = hist_run(hist_q, rx_raw);
				end
				else
					plock_d = plock_q + 1'b1;
			end
			else
			begin
				ref_d = chk_nx[6:0];
				bump = chk_nx[SYM_W+6:7] != rx_raw;
			end
		end
		if (miss && !fail_seen_q)
		begin
			fail_seen_d = 1'b1;
			exp_d = exp_b;
			act_d = rx_byte;
		end
		if ((miss || bump) && err_cnt != lbpt_pkg::CNT_SAT)
			cnt_d = err_cnt + 8'h01;
		if (!prbs_en)
		begin
			plocked_d = 1'b0;
			plock_d = '0;
		end
		if (!up_en)
			rx_st_d = RX_HUNT;
		// Zero write or re-enable restarts logging
		if (cnt_clr || up_rise)
		begin
			cnt_d = 8'h00;
			fail_seen_d = 1'b0;
			exp_d = 8'h00;
			act_d = 8'h00;
			hunt_d = '0;
		end
		if (up_rise)
		begin
			rx_st_d = RX_HUNT;
			rx_idx_d = 4'h0;
		end
	end

	// Lane state registers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_st_q <= TX_IDLE;
			tx_idx_q <= 4'h0;
			skip_cnt_q <= 12'h000;
			skip_due_q <= 1'b0;
			up_en_q <= 1'b0;
			tx_byte <= 8'h00;
			tx_k <= 1'b0;
			tx_raw <= '0;
			tx_raw_sel <= 1'b0;
			gen_q <= 7'h7F;
			rx_st_q <= RX_HUNT;
			rx_idx_q <= 4'h0;
			lock_q <= 2'd0;
			hunt_q <= '0;
			err_cnt <= 8'h00;
			exp_byte <= 8'h00;
			act_byte <= 8'h00;
			fail_seen_q <= 1'b0;
			hist_q <= 7'h00;
			ref_q <= 7'h00;
			plock_q <= '0;
			plocked_q <= 1'b0;
		end
		else
		begin
			tx_st_q <= tx_st_d;
			tx_idx_q <= tx_idx_d;
			skip_cnt_q <= skip_cnt_d;
			skip_due_q <= skip_due_d;
			up_en_q <= up_en;
			tx_byte <= tx_byte_d;
			tx_k <= tx_k_d;
			tx_raw <= tx_raw_d;
			tx_raw_sel <= prbs_en;
			gen_q <= gen_d;
			rx_st_q <= rx_st_d;
			rx_idx_q <= rx_idx_d;
			lock_q <= lock_d;
			hunt_q <= hunt_d;
			err_cnt <= cnt_d;
			exp_byte <= exp_d;
			act_byte <= act_d;
			fail_seen_q <= fail_seen_d;
			hist_q <= hist_d;
			ref_q <= ref_d;
			plock_q <= plock_d;
			plocked_q <= plocked_d;
		end
	end

endmodule : lbpt_lane

module lbpt_tester #(
	parameter int SYM_W = 10,
	parameter int SYNC_WAIT = 1024,
	parameter int PRBS_LOCK_N = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	// Configuration access
	input wire logic cfg_req,
	input wire logic cfg_we,
	input wire logic [11:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	// Per-lane receive data
	input wire logic [2:0] rx_valid,
	input wire logic [2:0][7:0] rx_byte,
	input wire logic [2:0] rx_k,
	input wire logic [2:0] rx_com_hit,
	input wire logic [2:0] rx_com_slip,
	input wire logic [2:0][SYM_W-1:0] rx_raw,
	// Per-lane transmit data
	output logic [2:0][7:0] tx_byte,
	output logic [2:0] tx_k,
	output logic [2:0] tx_pat_sel,
	output logic [2:0][SYM_W-1:0] tx_raw,
	output logic [2:0] tx_raw_sel
);
	logic [3:0][31:0] pat_q; // Shared pattern, all lanes
	logic [15:0] kflag_q;
	logic [2:0] up_en_q, prbs_en_q;
	logic [11:0] skip_int_q;
	logic [1:0] sel_q;
	logic [2:0] clr_q; // One-cycle counter clear per lane
	logic [2:0][7:0] cnt, expv, actv;
	logic [31:0] rd_d;
	logic [1:0] slot;
	logic wr;

	assign wr = cfg_req && cfg_we;

	// Select code to lane slot; reserved code reads empty
	always_comb
	begin
		unique case (sel_q)
			lbpt_pkg::SEL_LANE0: slot = 2'd0;
			lbpt_pkg::SEL_LANE2: slot = 2'd1;
			lbpt_pkg::SEL_PHY: slot = 2'd2;
			default: slot = 2'd3;
		endcase
	end

	// Read mux
	always_comb
	begin
		rd_d = 32'h0000_0000;
		unique case (cfg_addr)
			lbpt_pkg::OFS_PAT0: rd_d = pat_q[0];
			lbpt_pkg::OFS_PAT1: rd_d = pat_q[1];
			lbpt_pkg::OFS_PAT2: rd_d = pat_q[2];
			lbpt_pkg::OFS_PAT3: rd_d = pat_q[3];
			lbpt_pkg::OFS_CMD_STAT: rd_d[31:16] = kflag_q;
			lbpt_pkg::OFS_TEST_CTL:
			begin
				rd_d[lbpt_pkg::UP_EN_BIT0] = up_en_q[0];
				rd_d[lbpt_pkg::UP_EN_BIT1] = up_en_q[1];
				rd_d[lbpt_pkg::UP_EN_BIT2] = up_en_q[2];
			end
			lbpt_pkg::OFS_SKIP_CTL: rd_d[11:0] = skip_int_q;
			lbpt_pkg::OFS_DIAG:
			begin
				rd_d[lbpt_pkg::DIAG_SEL_LSB +: 2] = sel_q;
				if (slot != 2'd3)
				begin
					rd_d[lbpt_pkg::DIAG_CNT_LSB +: 8] = cnt[slot];
					rd_d[lbpt_pkg::DIAG_TYPE_BIT] = prbs_en_q[slot];
					// Byte capture only meaningful for user pattern
					rd_d[lbpt_pkg::DIAG_EXP_LSB +: 8] = expv[slot];
					rd_d[lbpt_pkg::DIAG_ACT_LSB +: 8] = actv[slot];
				end
			end
			lbpt_pkg::OFS_SERIALIZER_TEST_CONTROL:
			begin
				rd_d[lbpt_pkg::PRBS_EN_BIT0] = prbs_en_q[0];
				rd_d[lbpt_pkg::PRBS_EN_BIT1] = prbs_en_q[1];
				rd_d[lbpt_pkg::PRBS_EN_BIT2] = prbs_en_q[2];
			end
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// Register writes; both enables set together is left to software
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pat_q <= '0;
			kflag_q <= 16'h0000;
			up_en_q <= 3'h0;
			prbs_en_q <= 3'h0;
			skip_int_q <= lbpt_pkg::SKIP_INTERVAL_RST;
			sel_q <= lbpt_pkg::SEL_LANE0;
			clr_q <= 3'h0;
			cfg_ack <= 1'b0;
			cfg_rdata <= 32'h0000_0000;
			tx_pat_sel <= 3'h0;
		end
		else
		begin
			cfg_ack <= cfg_req;
			cfg_rdata <= (cfg_req && !cfg_we) ? rd_d : 32'h0000_0000;
			tx_pat_sel <= up_en_q;
			clr_q <= 3'h0;
			if (wr && cfg_addr[11:4] == lbpt_pkg::OFS_PAT0[11:4])
				pat_q[cfg_addr[3:2]] <= cfg_wdata;
			if (wr && cfg_addr == lbpt_pkg::OFS_CMD_STAT)
				kflag_q <= cfg_wdata[lbpt_pkg::KFLAG_LSB +: 16];
			if (wr && cfg_addr == lbpt_pkg::OFS_TEST_CTL)
				up_en_q <= {cfg_wdata[lbpt_pkg::UP_EN_BIT2],
					cfg_wdata[lbpt_pkg::UP_EN_BIT1],
					cfg_wdata[lbpt_pkg::UP_EN_BIT0]};
			if (wr && cfg_addr == lbpt_pkg::OFS_SKIP_CTL)
				skip_int_q <= cfg_wdata[11:0];
			if (wr && cfg_addr == lbpt_pkg::OFS_SERIALIZER_TEST_CONTROL)
				prbs_en_q <= {cfg_wdata[lbpt_pkg::PRBS_EN_BIT2],
					cfg_wdata[lbpt_pkg::PRBS_EN_BIT1],
					cfg_wdata[lbpt_pkg::PRBS_EN_BIT0]};
			if (wr && cfg_addr == lbpt_pkg::OFS_DIAG)
			begin
				sel_q <= cfg_wdata[lbpt_pkg::DIAG_SEL_LSB +: 2];
				// Zero in the count field clears the lane being selected
				if (cfg_wdata[lbpt_pkg::DIAG_CNT_LSB +: 8] == 8'h00)
				begin
					unique case (cfg_wdata[lbpt_pkg::DIAG_SEL_LSB +: 2])
						lbpt_pkg::SEL_LANE0: clr_q <= 3'h1;
						lbpt_pkg::SEL_LANE2: clr_q <= 3'h2;
						lbpt_pkg::SEL_PHY: clr_q <= 3'h4;
						default: clr_q <= 3'h0;
					endcase
				end
			end
		end
	end

	// One independent engine per lane
	for (genvar g = 0; g < lbpt_pkg::NUM_LANES; g++)
	begin : g_lane
		lbpt_lane #(
			.SYM_W(SYM_W),
			.SYNC_WAIT(SYNC_WAIT),
			.PRBS_LOCK_N(PRBS_LOCK_N)
		) u_lane (
			.clk(clk),
			.arst_n(arst_n),
			.up_en(up_en_q[g]),
			.prbs_en(prbs_en_q[g]),
			.pattern(pat_q),
			.kflags(kflag_q),
			.skip_interval(skip_int_q),
			.cnt_clr(clr_q[g]),
			.rx_valid(rx_valid[g]),
			.rx_byte(rx_byte[g]),
			.rx_k(rx_k[g]),
			.rx_com_hit(rx_com_hit[g]),
			.rx_com_slip(rx_com_slip[g]),
			.rx_raw(rx_raw[g]),
			.tx_byte(tx_byte[g]),
			.tx_k(tx_k[g]),
			.tx_raw(tx_raw[g]),
			.tx_raw_sel(tx_raw_sel[g]),
			.err_cnt(cnt[g]),
			.exp_byte(expv[g]),
			.act_byte(actv[g])
		);
	end

endmodule : lbpt_tester

//--- lbpt_tester_assertions.sv
module lbpt_tester_assertions #(
	parameter int SYM_W = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register access
	input wire logic cfg_req,
	input wire logic cfg_we,
	input wire logic [11:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic cfg_ack,
	input wire logic [31:0] cfg_rdata,
	// Lane transmit side
	input wire logic [2:0][7:0] tx_byte,
	input wire logic [2:0] tx_k,
	input wire logic [2:0] tx_pat_sel,
	input wire logic [2:0][SYM_W-1:0] tx_raw,
	input wire logic [2:0] tx_raw_sel
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// Enable writes for lane 0 pattern and lane 2 PRBS
	logic up_wr;
	logic prbs_wr;
	assign up_wr = cfg_req && cfg_we && cfg_wdata[28]
		&& cfg_addr == lbpt_pkg::OFS_TEST_CTL;
	assign prbs_wr = cfg_req && cfg_we && cfg_wdata[18]
		&& cfg_addr == lbpt_pkg::OFS_SERIALIZER_TEST_CONTROL;

	a_ack_one_cycle: assert property (cfg_req |=> cfg_ack)
		else $error("missing access acknowledge");
	a_pat_start: assert property (up_wr |-> ##[1:2] tx_pat_sel[0])
		else $error("pattern path not selected");
	a_sync_first: assert property ($rose(tx_pat_sel[0]) |=>
		tx_byte[0] == 8'h31 ##1 tx_byte[0] == 8'h4D
		##1 tx_byte[0] == 8'h52 ##1 tx_byte[0] == 8'h43)
		else $error("sync word not sent first");
	a_sync_data_sym: assert property ($rose(tx_pat_sel[0]) |=>
		!tx_k[0] [*4])
		else $error("sync byte sent as control");
	a_skip_set_shape: assert property ($past(tx_pat_sel[0]) && tx_k[0]
		&& tx_byte[0] == lbpt_pkg::SYM_COM |=> (!tx_pat_sel[0]
		|| (tx_k[0] && tx_byte[0] == lbpt_pkg::SYM_SKP)) [*3])
		else $error("malformed skip set");
	a_prbs_start: assert property (prbs_wr |-> ##[1:2] tx_raw_sel[1])
		else $error("raw path not selected");
	a_prbs_each_clk: assert property (tx_raw_sel[1] && $past(tx_raw_sel[1])
		|-> tx_raw[1] != $past(tx_raw[1]))
		else $error("raw symbol not renewed");
	a_sel_reserved: assert property (cfg_ack
		&& $past(cfg_addr == lbpt_pkg::OFS_DIAG)
		&& cfg_rdata[25:24] == lbpt_pkg::SEL_RSVD
		|-> cfg_rdata[23:0] == 24'h000000 && !cfg_rdata[30])
		else $error("reserved select shows status");
endmodule : lbpt_tester_assertions

bind lbpt_tester lbpt_tester_assertions #(.SYM_W(SYM_W)) i_chk (
	.clk(clk),
	.arst_n(arst_n),
	.cfg_req(cfg_req),
	.cfg_we(cfg_we),
	.cfg_addr(cfg_addr),
	.cfg_wdata(cfg_wdata),
	.cfg_ack(cfg_ack),
	.cfg_rdata(cfg_rdata),
	.tx_byte(tx_byte),
	.tx_k(tx_k),
	.tx_pat_sel(tx_pat_sel),
	.tx_raw(tx_raw),
	.tx_raw_sel(tx_raw_sel)
);

//--- lbpt_loop_slave.sv
module lbpt_loop_slave #(
	parameter int SYM_W = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// From the tester
	input wire logic [7:0] tx_byte,
	input wire logic tx_k,
	input wire logic tx_sel,
	input wire logic [SYM_W-1:0] tx_raw,
	// Fault controls
	input wire logic flip,
	input wire logic cut,
	// Back to the tester
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic rx_k,
	output logic rx_com_hit,
	output logic [SYM_W-1:0] rx_raw
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] byte_q; // Looped byte
	logic k_q;
	logic val_q;
	logic [SYM_W-1:0] raw_q; // Looped raw symbol
	logic [2:0] train_q; // Training age

	// One cycle loop, no elastic slack
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			byte_q <= 8'h00;
			k_q <= 1'b0;
			val_q <= 1'b0;
			raw_q <= '0;
			train_q <= 3'h0;
		end
		else
		begin
			// Idle line shows the inverse, not a stale copy
			byte_q <= tx_sel ? tx_byte : ~byte_q;
			k_q <= tx_sel & tx_k;
			val_q <= tx_sel;
			// Returned raw symbols share the tester clock
			raw_q <= tx_raw;
			if (train_q != 3'h7)
				train_q <= train_q + 3'h1;
		end
	end

	// Three aligned commas early on, as training would give
	assign rx_com_hit = train_q >= 3'h2 && train_q <= 3'h4;
	assign rx_valid = val_q & ~cut;
	assign rx_byte = byte_q ^ {7'h00, flip};
	assign rx_k = k_q;
	assign rx_raw = raw_q ^ {SYM_W{flip}};
endmodule : lbpt_loop_slave

//--- lbpt_tester_tb_top.sv
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end

module lbpt_tester_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SYM_W = 10;
	// Clock, reset and bus
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cfg_req = 1'b0;
	logic cfg_we = 1'b0;
	logic [11:0] cfg_addr = 12'h000;
	logic [31:0] cfg_wdata = 32'h0000_0000;
	logic cfg_ack;
	logic [31:0] cfg_rdata;
	// Lane traffic
	logic [2:0] rx_valid, rx_k, rx_com_hit, tx_k, tx_pat_sel, tx_raw_sel;
	logic [2:0][7:0] rx_byte, tx_byte;
	logic [2:0][SYM_W-1:0] rx_raw, tx_raw;
	logic [2:0] flip = 3'h0; // Corrupt one return
	logic [2:0] cut = 3'h0; // Drop valid on return
	logic [2:0] slip = 3'h0; // Comma seen off the locked position
	int errors = 0;
	int check_count = 0;
	logic [31:0] pat [4] = '{32'h1122_33FB, 32'h4455_6677, 32'h8899_AABB,
		32'hCCDD_EE0F};
	logic [31:0] prbs_seq [4] = '{32'h0000_3074, 32'h000E_3034,
		32'h000E_3035, 32'h000E_3034};
	logic [31:0] d;
	logic [7:0] b;

	// 50 MHz clock
	always #10ns clk = ~clk;

	lbpt_tester #(.SYM_W(SYM_W), .SYNC_WAIT(16), .PRBS_LOCK_N(4)) i_dut (
		.clk(clk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_we(cfg_we),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
		.cfg_rdata(cfg_rdata), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.rx_k(rx_k), .rx_com_hit(rx_com_hit), .rx_com_slip(slip),
		.rx_raw(rx_raw), .tx_byte(tx_byte), .tx_k(tx_k),
		.tx_pat_sel(tx_pat_sel), .tx_raw(tx_raw), .tx_raw_sel(tx_raw_sel));

	// One looping far end per lane
	for (genvar i = 0; i < 3; i++)
	begin : g_far
		lbpt_loop_slave #(.SYM_W(SYM_W)) i_far (.clk(clk), .arst_n(arst_n),
			.tx_byte(tx_byte[i]), .tx_k(tx_k[i]),
			.tx_sel(tx_pat_sel[i] | tx_raw_sel[i]),
			.tx_raw(tx_raw[i]), .flip(flip[i]), .cut(cut[i]),
			.rx_valid(rx_valid[i]), .rx_byte(rx_byte[i]), .rx_k(rx_k[i]),
			.rx_com_hit(rx_com_hit[i]), .rx_raw(rx_raw[i]));
	end

	// Counts and verdict
	task automatic end_sim;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	// Single write, taken at one rising edge
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(negedge clk);
		cfg_req = 1'b1;
		cfg_we = 1'b1;
		cfg_addr = a;
		cfg_wdata = v;
		@(posedge clk);
		@(negedge clk);
		cfg_req = 1'b0;
	endtask : wr

	// Single read, data stands one cycle with the acknowledge
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(negedge clk);
		cfg_req = 1'b1;
		cfg_we = 1'b0;
		cfg_addr = a;
		@(posedge clk);
		@(negedge clk);
		cfg_req = 1'b0;
		`CHK(cfg_ack, 1'b1)
		v = cfg_rdata;
	endtask : rd

	// Select a lane without clearing it, then read its status
	task automatic diag(input logic [1:0] s, input logic [7:0] c,
		input logic t);
		wr(lbpt_pkg::OFS_DIAG, {6'h00, s, 8'hFF, 16'h0000});
		rd(lbpt_pkg::OFS_DIAG, d);
		`CHK(d[23:16], c)
		`CHK(d[30], t)
	endtask : diag

	// Corrupt one returned data byte, never a control symbol
	task automatic inject(input int i);
		@(negedge clk);
		while (!(rx_valid[i] && !rx_k[i]))
			@(negedge clk);
		b = rx_byte[i];
		flip[i] = 1'b1;
		@(negedge clk);
		flip[i] = 1'b0;
	endtask : inject

	// Main sequence
	initial
	begin
		repeat (5) @(negedge clk);
		arst_n = 1'b1;
		rd(lbpt_pkg::OFS_SKIP_CTL, d);
		`CHK(d[11:0], 12'h49C)
		rd(12'h300, d);
		`CHK(d, 32'h0000_0000)
		for (int i = 0; i < 4; i++)
			wr(lbpt_pkg::OFS_PAT0 + 12'(4 * i), pat[i]);
		rd(lbpt_pkg::OFS_PAT3, d);
		`CHK(d, pat[3])
		wr(lbpt_pkg::OFS_CMD_STAT, 32'h0001_0000);
		wr(lbpt_pkg::OFS_SKIP_CTL, 32'h0000_0028);
		// Far end already looping when the enables go up
		wr(lbpt_pkg::OFS_TEST_CTL, 32'hD000_0000);
		repeat (2) @(negedge clk);
		for (int j = 0; j < 20; j++)
		begin
			b = j < 4 ? lbpt_pkg::SYNC_WORD[31 - 8 * j -: 8]
				: pat[(j - 4) / 4][8 * (j % 4) +: 8];
			for (int i = 0; i < 3; i++)
			begin
				`CHK(tx_byte[i], b)
				`CHK(tx_k[i], 1'(j == 4))
			end
			@(negedge clk);
		end
		// Several skip sets pass through the loop
		repeat (200) @(negedge clk);
		for (int s = 0; s < 4; s++)
			diag(2'(s), 8'h00, 1'b0);
		inject(0);
		diag(lbpt_pkg::SEL_LANE0, 8'h01, 1'b0);
		`CHK(d[15:0], {b ^ 8'h01, b})
		wr(lbpt_pkg::OFS_DIAG, 32'h0000_0000);
		diag(lbpt_pkg::SEL_LANE0, 8'h00, 1'b0);
		inject(0);
		cut[2] = 1'b1;
		// Lane 2 loses symbol lock, so its next sync hunt must fail
		slip[1] = 1'b1;
		@(negedge clk);
		slip[1] = 1'b0;
		wr(lbpt_pkg::OFS_TEST_CTL, 32'h0000_0000);
		wr(lbpt_pkg::OFS_TEST_CTL, 32'hD000_0000);
		repeat (40) @(negedge clk);
		diag(lbpt_pkg::SEL_LANE0, 8'h00, 1'b0);
		diag(lbpt_pkg::SEL_PHY, 8'hFF, 1'b0);
		diag(lbpt_pkg::SEL_LANE2, 8'hFF, 1'b0);
		// Pattern off before the raw engine, never both
		wr(lbpt_pkg::OFS_TEST_CTL, 32'h0000_0000);
		for (int i = 0; i < 4; i++)
			wr(lbpt_pkg::OFS_SERIALIZER_TEST_CONTROL, prbs_seq[i]);
		repeat (20) @(negedge clk);
		wr(lbpt_pkg::OFS_DIAG, {6'h00, lbpt_pkg::SEL_LANE2, 24'h000000});
		diag(lbpt_pkg::SEL_LANE2, 8'h00, 1'b1);
		flip[1] = 1'b1;
		@(negedge clk);
		flip[1] = 1'b0;
		diag(lbpt_pkg::SEL_LANE2, 8'h01, 1'b1);
		end_sim;
	end

	// Watchdog, well beyond the expected run of about 380 cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		end_sim;
	end
endmodule : lbpt_tester_tb_top
